// File: lgkd_pkg.sv
/*
 * lgkd_pkg: constants, parameter RAM map and types of the loop closure
 * and ground key detector block.
 * assumes: included before every other file of the block.
 */
package lgkd_pkg;

	// ******************************************************************
	// parameter RAM map
	// ******************************************************************
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned WORD_W   = 16;
	localparam logic [7:0] LOOP_SEIZE_ADDR     = 8'h16;
	localparam logic [7:0] LOOP_RELEASE_ADDR   = 8'h17;
	localparam logic [7:0] LOOP_DBI_ADDR       = 8'h18;
	localparam logic [7:0] GK_DETECT_ADDR      = 8'h1B;
	localparam logic [7:0] GK_REMOVAL_ADDR     = 8'h1C;
	localparam logic [7:0] GK_DBI_ADDR         = 8'h1D;
	localparam logic [15:0] LOOP_SEIZE_RST     = 16'h0000;
	localparam logic [15:0] LOOP_RELEASE_RST   = 16'h0000;
	localparam logic [15:0] LOOP_DBI_RST       = 16'h0000;
	localparam logic [15:0] GK_DETECT_RST      = 16'h0000;
	localparam logic [15:0] GK_REMOVAL_RST     = 16'h0000;
	localparam logic [15:0] GK_DBI_RST         = 16'h0000;
	localparam logic [15:0] UNMAPPED_DATA      = 16'h0000;

	// ******************************************************************
	// scaling of threshold words
	// ******************************************************************
	// 3.097 uA per lsb, compared at 396.4 uA, i.e. 128 lsb per step
	localparam real CURRENT_UA_PER_LSB = 3.097;
	localparam real EFFECTIVE_RES_UA   = 396.4;
	localparam int unsigned RES_SHIFT  = 7;
	localparam int unsigned SIGN_BIT   = 15;
	// word range is 0 to 101.09 mA: positive half of the 16-bit word
	localparam real RANGE_MA           = 101.09;
	localparam real LOOP_USABLE_MA     = 61.0;
	localparam real GK_USABLE_MA       = 16.0;

	// ******************************************************************
	// timing
	// ******************************************************************
	localparam int unsigned CLK_PERIOD_NS  = 8;
	localparam int unsigned DBI_LSB_NS     = 1250000; // 1.25 ms per lsb
	localparam real         DBI_MAX_S      = 40.96;
	localparam int unsigned DBI_TICK_CYCLES = DBI_LSB_NS / CLK_PERIOD_NS;
	localparam int unsigned NUM_DET        = 2;
	localparam int unsigned DET_LOOP       = 0;
	localparam int unsigned DET_GK         = 1;

	// ******************************************************************
	// types
	// ******************************************************************
	typedef enum logic [0:0] {
		LGKD_IDLE   = 1'b0,
		LGKD_ACTIVE = 1'b1
	} lgkd_state_t;

endpackage

// File: lgkd_det_if.sv
/*
 * lgkd_det_if: signals between the top level and one hysteresis and
 * debounce detector.
 * assumes: all signals on the block clock.
 */
`timescale 1ns/10ps
interface lgkd_det_if;
	logic [15:0] meas;     // measured current word
	logic [15:0] set_th;   // threshold that raises the state
	logic [15:0] clr_th;   // threshold that drops the state
	logic [15:0] dbi;      // debounce interval in ticks
	logic        tick;     // one pulse per debounce lsb
	logic        active;   // qualified state
	logic        change;   // one-cycle pulse on qualified change

	modport ctrl (output meas, output set_th, output clr_th, output dbi,
		output tick, input active, input change);
	modport det (input meas, input set_th, input clr_th, input dbi,
		input tick, output active, output change);
endinterface // lgkd_det_if

// File: lgkd_detector.sv
/*
 * lgkd_detector: one threshold comparator with hysteresis and debounce.
 * assumes: meas and thresholds come from the same clock domain; tick
 * is a one-cycle pulse at the debounce lsb rate.
 */
`timescale 1ns/10ps
module lgkd_detector
	import lgkd_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    rst,
	lgkd_det_if.det      dif
);

	// ******************************************************************
	// comparison at effective resolution
	// ******************************************************************
	logic [15:0] meas_mag;
	logic [15:0] set_mag;
	logic [15:0] clr_mag;
	logic        cond;
	lgkd_state_t state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic        change_q, change_d;

	// negative readings count as zero current; low bits are below
	// the comparison step, so they are dropped on both sides
	always_comb begin
		meas_mag = dif.meas[SIGN_BIT] ? 16'h0000
			: (dif.meas >> RES_SHIFT);
		set_mag  = {1'b0, dif.set_th[14:0]} >> RES_SHIFT;
		clr_mag  = {1'b0, dif.clr_th[14:0]} >> RES_SHIFT;
		// idle waits for the raise level, active for the drop level
		if (state_q == LGKD_IDLE) begin
			cond = (meas_mag >= set_mag);
		end else begin
			cond = (meas_mag <= clr_mag);
		end
	end

	// ******************************************************************
	// debounce and state
	// ******************************************************************
	// counter restarts whenever the condition breaks, so a glitch
	// shorter than the interval less one lsb never reaches software
	always_comb begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		change_d = 1'b0;
		if (!cond) begin
			cnt_d = 16'h0000;
		end else if (cnt_q >= dif.dbi) begin
			state_d  = (state_q == LGKD_IDLE) ? LGKD_ACTIVE : LGKD_IDLE;
			change_d = 1'b1;
			cnt_d    = 16'h0000;
		end else if (dif.tick) begin
			cnt_d = cnt_q + 16'h0001;
		end
	end

	// register stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q  <= LGKD_IDLE;
			cnt_q    <= 16'h0000;
			change_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			change_q <= change_d;
		end
	end

	assign dif.active = (state_q == LGKD_ACTIVE);
	assign dif.change = change_q;

endmodule // lgkd_detector

// File: lgkd_top.sv
/*
 * lgkd_top: loop closure and ground key detection of one line channel,
 * with its threshold and interval words in the parameter RAM.
 * assumes: measured currents arrive on clk from the measurement path;
 * the RAM port is driven by the serial host interface on clk.
 */
//
// Contract
// - loop closure ends when loop current falls to release threshold.
// - thresholds span 0 to 101.09 mA, compared at 396.4 uA steps.
// - ground key debounced by programmed interval, 1.25 ms per lsb.
// - ground key valid when longitudinal current reaches detect level.
// - ground key uses separate removal threshold for hysteresis.
// - ground key ends when longitudinal current falls to removal level.
// - loop closure valid when loop current reaches seize threshold.
// - loop closure debounced by its own interval, 1.25 ms per lsb.
`timescale 1ns/10ps
module lgkd_top
	import lgkd_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = DBI_TICK_CYCLES
)(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] loop_current,
	input  wire logic [15:0] long_current,
	input  wire logic        ram_wr,
	input  wire logic        ram_rd,
	input  wire logic [7:0]  ram_addr,
	input  wire logic [15:0] ram_wdata,
	output logic      [15:0] ram_rdata,
	output logic             ram_rvalid,
	output logic             loop_closed,
	output logic             loop_change,
	output logic             ground_key,
	output logic             ground_key_change
);

	// ******************************************************************
	// parameter RAM words
	// ******************************************************************
	// word map as the host sees it, every word 16 bits, read and write:
	//   0x16 loop seize threshold, raises loop_closed
	//   0x17 loop release threshold, drops loop_closed
	//   0x18 loop closure debounce interval
	//   0x1B ground key detect threshold, raises ground_key
	//   0x1C ground key removal threshold, drops ground_key
	//   0x1D ground key debounce interval
	// words hold their value until rewritten or reset
	logic [15:0] seize_q, seize_d;
	logic [15:0] release_q, release_d;
	logic [15:0] loop_dbi_q, loop_dbi_d;
	logic [15:0] gk_det_q, gk_det_d;
	logic [15:0] gk_rem_q, gk_rem_d;
	logic [15:0] gk_dbi_q, gk_dbi_d;
	logic [15:0] rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;

	// write decode; unknown addresses are ignored
	always_comb begin
		seize_d    = seize_q;
		release_d  = release_q;
		loop_dbi_d = loop_dbi_q;
		gk_det_d   = gk_det_q;
		gk_rem_d   = gk_rem_q;
		gk_dbi_d   = gk_dbi_q;
		if (ram_wr) begin
			case (ram_addr)
			LOOP_SEIZE_ADDR: begin
				seize_d = ram_wdata;
			end
			LOOP_RELEASE_ADDR: begin
				release_d = ram_wdata;
			end
			LOOP_DBI_ADDR: begin
				loop_dbi_d = ram_wdata;
			end
			GK_DETECT_ADDR: begin
				gk_det_d = ram_wdata;
			end
			GK_REMOVAL_ADDR: begin
				gk_rem_d = ram_wdata;
			end
			GK_DBI_ADDR: begin
				gk_dbi_d = ram_wdata;
			end
			default: begin
			end
			endcase
		end
	end

	// read decode; data one cycle after the strobe, zero if unmapped
	always_comb begin
		rvalid_d = ram_rd;
		rdata_d  = rdata_q;
		if (ram_rd) begin
			case (ram_addr)
			LOOP_SEIZE_ADDR: begin
				rdata_d = seize_q;
			end
			LOOP_RELEASE_ADDR: begin
				rdata_d = release_q;
			end
			LOOP_DBI_ADDR: begin
				rdata_d = loop_dbi_q;
			end
			GK_DETECT_ADDR: begin
				rdata_d = gk_det_q;
			end
			GK_REMOVAL_ADDR: begin
				rdata_d = gk_rem_q;
			end
			GK_DBI_ADDR: begin
				rdata_d = gk_dbi_q;
			end
			default: begin
				rdata_d = UNMAPPED_DATA;
			end
			endcase
		end
	end

	// register stage of the RAM words
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seize_q    <= LOOP_SEIZE_RST;
			release_q  <= LOOP_RELEASE_RST;
			loop_dbi_q <= LOOP_DBI_RST;
			gk_det_q   <= GK_DETECT_RST;
			gk_rem_q   <= GK_REMOVAL_RST;
			gk_dbi_q   <= GK_DBI_RST;
			rdata_q    <= 16'h0000;
			rvalid_q   <= 1'b0;
		end else begin
			seize_q    <= seize_d;
			release_q  <= release_d;
			loop_dbi_q <= loop_dbi_d;
			gk_det_q   <= gk_det_d;
			gk_rem_q   <= gk_rem_d;
			gk_dbi_q   <= gk_dbi_d;
			rdata_q    <= rdata_d;
			rvalid_q   <= rvalid_d;
		end
	end

	// ******************************************************************
	// debounce time base
	// ******************************************************************
	// shared by both detectors; a debounce may therefore run up to one
	// lsb short, traded for a single large counter
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
	logic [31:0] tick_cnt_q, tick_cnt_d;
	logic        tick_q, tick_d;

	// one tick per TICK_CYCLES clocks, wrapping on the last count
	always_comb begin
		tick_d     = 1'b0;
		tick_cnt_d = tick_cnt_q + 32'h0000_0001;
		if (tick_cnt_q >= TICK_LAST) begin
			tick_cnt_d = 32'h0000_0000;
			tick_d     = 1'b1;
		end
	end

	// register stage of the time base
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q     <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q     <= tick_d;
		end
	end

	// ******************************************************************
	// detectors
	// ******************************************************************
	logic [15:0] det_meas [NUM_DET];
	logic [15:0] det_set  [NUM_DET];
	logic [15:0] det_clr  [NUM_DET];
	logic [15:0] det_dbi  [NUM_DET];
	logic        det_act  [NUM_DET];
	logic        det_chg  [NUM_DET];

	// loop uses seize/release, ground key detect/removal
	assign det_meas[DET_LOOP] = loop_current;
	assign det_set[DET_LOOP]  = seize_q;
	assign det_clr[DET_LOOP]  = release_q;
	assign det_dbi[DET_LOOP]  = loop_dbi_q;
	assign det_meas[DET_GK]   = long_current;
	assign det_set[DET_GK]    = gk_det_q;
	assign det_clr[DET_GK]    = gk_rem_q;
	assign det_dbi[DET_GK]    = gk_dbi_q;

	// one detector per measured current; both share the tick, so they
	// differ only in the current and the words that feed them
	for (genvar g = 0; g < NUM_DET; g++) begin : g_det
		lgkd_det_if dif ();
		assign dif.meas   = det_meas[g];
		assign dif.set_th = det_set[g];
		assign dif.clr_th = det_clr[g];
		assign dif.dbi    = det_dbi[g];
		assign dif.tick   = tick_q;
		assign det_act[g] = dif.active;
		assign det_chg[g] = dif.change;
		lgkd_detector u_det (
			.clk (clk),
			.rst (rst),
			.dif (dif)
		);
	end

	// ******************************************************************
	// outputs, all straight from flip-flops
	// ******************************************************************
	assign ram_rdata         = rdata_q;
	assign ram_rvalid        = rvalid_q;
	assign loop_closed       = det_act[DET_LOOP];
	assign loop_change       = det_chg[DET_LOOP];
	assign ground_key        = det_act[DET_GK];
	assign ground_key_change = det_chg[DET_GK];

endmodule // lgkd_top

// File: lgkd_monitor.sv
/* lgkd_monitor: port checks of lgkd_top, keeps its own copy of the words.
 * assumes: one clock, rst async active high, bound to every lgkd_top. */
`timescale 1ns/10ps
module lgkd_monitor
	import lgkd_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = DBI_TICK_CYCLES
)(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [15:0] loop_current,
	input wire logic [15:0] long_current,
	input wire logic        ram_wr,
	input wire logic        ram_rd,
	input wire logic [7:0]  ram_addr,
	input wire logic [15:0] ram_wdata,
	input wire logic [15:0] ram_rdata,
	input wire logic        ram_rvalid,
	input wire logic        loop_closed,
	input wire logic        loop_change,
	input wire logic        ground_key,
	input wire logic        ground_key_change
);
	// ************************************************
	// shadow of the parameter words
	// ************************************************
	logic [15:0] sh_q [0:7]; // address bits 2:0 are unique in the map
	logic [15:0] exp_q;
	logic        in_map;
	assign in_map = ram_addr inside {8'h16, 8'h17, 8'h18,
		8'h1B, 8'h1C, 8'h1D};

	// writes land at the taking edge, so a read sees the old word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sh_q  <= '{default: 16'h0000};
			exp_q <= 16'h0000;
		end else begin
			if (ram_wr && in_map) begin
				sh_q[ram_addr[2:0]] <= ram_wdata;
			end
			if (ram_rd) begin
				exp_q <= in_map ? sh_q[ram_addr[2:0]] : 16'h0000;
			end
		end
	end

	// only bits 14:7 count; a negative reading counts as zero
	function automatic logic [7:0] mag(logic [15:0] v);
		return v[15] ? 8'h00 : v[14:7];
	endfunction

	// ************************************************
	// assertions
	// ************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_read_answer: assert property (
		ram_rd |=> ram_rvalid && ram_rdata == exp_q)
		else $error("read answer wrong");
	a_answer_cause: assert property (
		ram_rvalid |-> $past(ram_rd))
		else $error("read valid without read");
	a_loop_flag: assert property (
		loop_change == (loop_closed != $past(loop_closed)))
		else $error("loop change flag wrong");
	a_gk_flag: assert property (
		ground_key_change == (ground_key != $past(ground_key)))
		else $error("ground key change flag wrong");
	a_loop_seize: assert property (
		!loop_closed && sh_q[0] == 16'h0000
		&& mag(loop_current) >= mag(sh_q[6]) |=> loop_closed)
		else $error("loop closure missed");
	a_loop_release: assert property (
		loop_closed && sh_q[0] == 16'h0000
		&& mag(loop_current) <= mag(sh_q[7]) |=> !loop_closed)
		else $error("loop release missed");
	a_gk_detect: assert property (
		!ground_key && sh_q[5] == 16'h0000
		&& mag(long_current) >= mag(sh_q[3]) |=> ground_key)
		else $error("ground key missed");
	a_gk_removal: assert property (
		ground_key && sh_q[5] == 16'h0000
		&& mag(long_current) <= mag(sh_q[4]) |=> !ground_key)
		else $error("ground key removal missed");
endmodule // lgkd_monitor

bind lgkd_top lgkd_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
	.clk(clk), .rst(rst), .loop_current(loop_current),
	.long_current(long_current), .ram_wr(ram_wr), .ram_rd(ram_rd),
	.ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
	.ram_rvalid(ram_rvalid), .loop_closed(loop_closed),
	.loop_change(loop_change), .ground_key(ground_key),
	.ground_key_change(ground_key_change));

// File: lgkd_tb_top.sv
/* lgkd_tb_top: self-checking bench of lgkd_top.
 * assumes: short debounce tick of 4 cycles, checker bound separately. */
`timescale 1ns/10ps
module lgkd_tb_top
	import lgkd_pkg::*;
;
	localparam int unsigned T = 4; // debounce tick, shortened
	logic        clk, rst, ram_wr, ram_rd, ram_rvalid;
	logic        loop_closed, loop_change, ground_key, ground_key_change;
	logic [15:0] loop_current, long_current, ram_wdata, ram_rdata;
	logic [7:0]  ram_addr;
	int          failures, total_checks, cycles;

	lgkd_top #(.TICK_CYCLES(T)) u_dut (.clk(clk), .rst(rst),
		.loop_current(loop_current), .long_current(long_current),
		.ram_wr(ram_wr), .ram_rd(ram_rd), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
		.ram_rvalid(ram_rvalid), .loop_closed(loop_closed),
		.loop_change(loop_change), .ground_key(ground_key),
		.ground_key_change(ground_key_change));

	// ************************************************
	// clock, hang guard, common tasks
	// ************************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// whole run needs about 130 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			complete_run();
		end
	end
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// strobes stay up between accesses; quiet() drops them
	task automatic wr(logic [7:0] a, logic [15:0] d);
		ram_rd = 1'b0;
		ram_wr = 1'b1;
		ram_addr = a;
		ram_wdata = d;
		step();
	endtask
	task automatic rd(logic [7:0] a, logic [15:0] e);
		ram_wr = 1'b0;
		ram_rd = 1'b1;
		ram_addr = a;
		step();
		chk("read_valid", 16'h0001, {15'h0000, ram_rvalid});
		chk("read_data", e, ram_rdata);
	endtask
	task automatic quiet();
		ram_wr = 1'b0;
		ram_rd = 1'b0;
		repeat (3) step();
	endtask
	// drive one current, expect the state to hold for k cycles
	task automatic hold(bit g, logic [15:0] v, int k, logic es);
		if (g) long_current = v;
		else loop_current = v;
		repeat (k) begin
			step();
			chk("held_state", {15'h0000, es},
				g ? ground_key : loop_closed);
			chk("held_change", 16'h0000,
				g ? ground_key_change : loop_change);
		end
	endtask
	// drive one current, expect a flip after lo..hi cycles
	task automatic meas(bit g, logic [15:0] v, logic es, int lo, int hi);
		int n;
		n = 0;
		if (g) long_current = v;
		else loop_current = v;
		do begin
			step();
			n++;
		end while ((g ? ground_key : loop_closed) !== es && n < 40);
		chk("new_state", {15'h0000, es},
			g ? ground_key : loop_closed);
		chk("change", 16'h0001,
			g ? ground_key_change : loop_change);
		chk("delay_in_range", 16'h0001,
			{15'h0000, n >= lo && n <= hi});
		step();
		chk("change_end", 16'h0000,
			g ? ground_key_change : loop_change);
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_regs();
		logic [7:0]  a [6] = '{8'h16, 8'h17, 8'h18, 8'h1B, 8'h1C, 8'h1D};
		logic [15:0] w [6] = '{16'h107F, 16'h0800, 16'h0000,
			16'h0600, 16'h0300, 16'h0000};
		foreach (a[i]) rd(a[i], 16'h0000);
		foreach (a[i]) wr(a[i], w[i]);
		wr(8'h19, 16'hFFFF);
		foreach (a[i]) rd(a[i], w[i]);
		rd(8'h19, 16'h0000);
		quiet();
	endtask
	// low seven bits of threshold and current do not count
	task automatic t_loop();
		hold(1'b0, 16'h0F80, 3, 1'b0);
		meas(1'b0, 16'h1000, 1'b1, 1, 1);
		hold(1'b0, 16'h0880, 3, 1'b1);
		meas(1'b0, 16'h087F, 1'b0, 1, 1);
		hold(1'b0, 16'h0C00, 3, 1'b0);
		meas(1'b0, 16'h1000, 1'b1, 1, 1);
		meas(1'b0, 16'hFFFF, 1'b0, 1, 1);
	endtask
	task automatic t_gk();
		hold(1'b1, 16'h0580, 3, 1'b0);
		meas(1'b1, 16'h0600, 1'b1, 1, 1);
		hold(1'b1, 16'h0380, 3, 1'b1);
		meas(1'b1, 16'h0300, 1'b0, 1, 1);
	endtask
	// free-running tick: D ticks take (D-1)*T+2 to D*T+1 cycles
	task automatic t_debounce();
		wr(8'h1D, 16'h0003);
		wr(8'h18, 16'h0002);
		quiet();
		hold(1'b1, 16'h0600, 6, 1'b0);
		hold(1'b1, 16'h0000, 2, 1'b0);
		meas(1'b1, 16'h0600, 1'b1, 2 * T + 2, 3 * T + 1);
		meas(1'b1, 16'h0000, 1'b0, 2 * T + 2, 3 * T + 1);
		meas(1'b0, 16'h1000, 1'b1, T + 2, 2 * T + 1);
		meas(1'b0, 16'h0000, 1'b0, T + 2, 2 * T + 1);
	endtask
	// mid-run reset clears the words and the outputs
	task automatic t_reset();
		wr(8'h1B, 16'h1234);
		rst = 1'b1;
		ram_wr = 1'b0;
		step();
		chk("reset_outputs", 16'h0000,
			{13'h0000, ground_key, loop_closed, ram_rvalid});
		rst = 1'b0;
		rd(8'h1B, 16'h0000);
		quiet();
	endtask

	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		failures = 0;
		total_checks = 0;
		rst = 1'b1;
		ram_wr = 1'b0;
		ram_rd = 1'b0;
		ram_addr = 8'h00;
		ram_wdata = 16'h0000;
		loop_current = 16'h0000;
		long_current = 16'h0000;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		t_regs();
		t_loop();
		t_gk();
		t_debounce();
		t_reset();
		complete_run();
	end
endmodule // lgkd_tb_top
